// ---- src/ddsc_top.sv ----
/*
 * Serial control of a dual 10-bit current converter: SPI or I2C slave
 * selected by a strap, feeding the command executor. Assumes all pins
 * are asynchronous to clk and the serial clock is far slower than clk.
 */
`timescale 1ns/100ps
`default_nettype none
module ddsc_top
    import ddsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spiSelect,
    input wire logic serialClk,
    input wire logic dataIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic chipSel_b,
    input wire logic addressStrapLow,
    input wire logic addressStrapHigh,
    output logic [VAL_W-1:0] channelACode,
    output logic [VAL_W-1:0] channelBCode,
    output logic [RANGE_W-1:0] channelARange,
    output logic [RANGE_W-1:0] channelBRange,
    output logic channelAEnable,
    output logic channelBEnable,
    output logic refExternal
);
    import ddsc_pkg::*;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_DATA = 3'b010,
        I2C_ACK = 3'b011,
        I2C_IGNORE = 3'b100
    } ddsc_i2c_state_type;

    // two-stage synchronisers; stage one feeds only stage two
    logic [4:0] syncA_r, syncB_r, prev_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncA_r <= 5'h1F;
            syncB_r <= 5'h1F;
            prev_r <= 5'h1F;
        end else begin
            syncA_r <= {spiSelect, serialClk, dataIn, chipSel_b, 1'b1};
            syncB_r <= syncA_r;
            prev_r <= syncB_r;
        end
    end

    // address straps are pins as well; two flops before the match compare
    logic [1:0] strapA_r, strapB_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strapA_r <= 2'h0;
            strapB_r <= 2'h0;
        end else begin
            strapA_r <= {addressStrapHigh, addressStrapLow};
            strapB_r <= strapA_r;
        end
    end

    wire modeSpi = syncB_r[4];
    wire sclS = syncB_r[3];
    wire sdaS = syncB_r[2];
    wire csS = syncB_r[1];
    wire sclRise = sclS && !prev_r[3];
    wire sclFall = !sclS && prev_r[3];
    // start/stop only while the clock stays high
    wire i2cStart = !modeSpi && sclS && prev_r[3] && !sdaS && prev_r[2];
    wire i2cStop = !modeSpi && sclS && prev_r[3] && sdaS && !prev_r[2];
    wire csRise = csS && !prev_r[1];

    // SPI: shift while selected, execute on select rising
    logic [FRAME_W-1:0] spiShift_r;
    logic [5:0] spiCount_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            spiShift_r <= '0;
            spiCount_r <= '0;
        end else if (!modeSpi || csS) begin
            spiCount_r <= '0;
        end else if (sclRise) begin
            spiShift_r <= {spiShift_r[FRAME_W-2:0], sdaS};
            if (spiCount_r != SPI_FRAME_BITS) begin
                spiCount_r <= spiCount_r + 6'h01;
            end
        end
    end
    // a short frame is executed as-is; the master must not cut it
    wire spiExec = modeSpi && csRise && (spiCount_r != '0);

    // I2C receiver
    ddsc_i2c_state_type st_r, st_nxt;
    logic [3:0] bitCnt_r;
    logic [7:0] byteSh_r;
    logic [1:0] byteIdx_r;
    logic [5:0] sclCount_r;
    logic [CMD_W+1:0] cmdByte_r;
    logic ackDrive_r;

    wire [7:0] ownAddr = {I2C_ADDR_FIXED, strapB_r, 1'b0};
    wire [7:0] shiftNext = {byteSh_r[6:0], sdaS};
    wire addrMatch = (shiftNext == ownAddr);
    wire byteDone = sclRise && (bitCnt_r == I2C_BITS_PER_BYTE - 4'h1);
    wire i2cExec = !modeSpi && sclRise && (st_r == I2C_DATA) && (byteIdx_r == 2'h2)
        && (sclCount_r == I2C_EXEC_CLOCK - 6'h01);

    // next-state for the byte sequencer
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            I2C_IDLE: st_nxt = I2C_IDLE;
            I2C_ADDR: begin
                if (byteDone) begin
                    st_nxt = addrMatch ? I2C_ACK : I2C_IGNORE;
                end
            end
            I2C_DATA: begin
                if (byteDone) begin
                    st_nxt = I2C_ACK;
                end
            end
            I2C_ACK: begin
                if (sclRise && byteIdx_r == 2'h3) begin
                    st_nxt = I2C_IGNORE; // extra bytes not acked
                end else if (sclRise) begin
                    st_nxt = I2C_DATA;
                end
            end
            I2C_IGNORE: st_nxt = I2C_IGNORE;
            default: st_nxt = I2C_IDLE;
        endcase
        if (modeSpi || i2cStop) begin
            st_nxt = I2C_IDLE;
        end else if (i2cStart) begin
            st_nxt = I2C_ADDR;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= I2C_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // bit and byte counting; clock count restarts at each START
    always_ff @(posedge clk) begin
        if (!rst_b || i2cStart || modeSpi) begin
            bitCnt_r <= '0;
            byteIdx_r <= '0;
            sclCount_r <= '0;
            byteSh_r <= '0;
        end else if (sclRise) begin
            sclCount_r <= sclCount_r + 6'h01;
            if (st_r == I2C_ACK) begin
                bitCnt_r <= '0;
            end else begin
                byteSh_r <= shiftNext;
                bitCnt_r <= byteDone ? '0 : bitCnt_r + 4'h1;
                if (byteDone && byteIdx_r != 2'h3) begin
                    byteIdx_r <= byteIdx_r + 2'h1;
                end
            end
        end
    end

    // first data byte holds command and value high bits
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmdByte_r <= '0;
        end else if (st_r == I2C_DATA && byteDone && byteIdx_r == 2'h1) begin
            cmdByte_r <= shiftNext;
        end
    end

    // ack drive: set on the falling edge entering the ninth clock, released
    // on the falling edge that ends it, so SDA stays low through its high;
    // leaving the ack state at the ninth rise must not let go of the line
    always_ff @(posedge clk) begin
        if (!rst_b || modeSpi) begin
            ackDrive_r <= 1'b0;
        end else if (i2cStart || i2cStop) begin
            ackDrive_r <= 1'b0;
        end else if (sclFall && ackDrive_r) begin
            ackDrive_r <= 1'b0;
        end else if (sclFall && st_r == I2C_ACK) begin
            ackDrive_r <= 1'b1;
        end
    end

    assign sdaOut = 1'b0; // open drain: only ever pulls low
    assign sdaOe = ackDrive_r && !modeSpi;

    // one execute strobe from whichever port is active
    wire execStb = spiExec || i2cExec;
    ddsc_cmd_type cmdIn;
    assign cmdIn = modeSpi ? spiShift_r
        : {cmdByte_r, shiftNext};

    ddsc_chan_type chanA, chanB;
    ddsc_exec u_exec (
        .clk(clk),
        .rst_b(rst_b),
        .execStb(execStb),
        .cmd(cmdIn),
        .chanA(chanA),
        .chanB(chanB),
        .refExternal(refExternal)
    );

    // shutdown only gates the outputs; registers still update
    assign channelACode = chanA.dacReg;
    assign channelBCode = chanB.dacReg;
    assign channelARange = chanA.range;
    assign channelBRange = chanB.range;
    assign channelAEnable = !chanA.shutdown;
    assign channelBEnable = !chanB.shutdown;
endmodule : ddsc_top
`default_nettype wire

// ---- src/ddsc_pkg.sv ----
/*
 * Package of the dual converter serial control: command codes, field
 * positions, power-on defaults and the grouped state of both channels.
 * Assumes nothing of its surroundings; shared by the control and the
 * command executor.
 */
package ddsc_pkg;
    localparam int VAL_W = 10;
    localparam int CMD_W = 6;
    localparam int FRAME_W = 16;
    localparam int RANGE_W = 3;
    localparam logic [4:0] I2C_ADDR_FIXED = 5'h0C;
    localparam logic [5:0] SPI_FRAME_BITS = 6'h10;
    localparam logic [5:0] I2C_EXEC_CLOCK = 6'h1A;
    localparam logic [3:0] I2C_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] I2C_ACK_SLOT = 4'h9;
    localparam logic [RANGE_W-1:0] RANGE_DEFAULT = 3'h0;
    localparam logic [RANGE_W-1:0] RANGE_TOP = 3'h5;
    localparam logic REF_EXTERNAL = 1'b1;

    localparam logic [5:0] CMD_NOP = 6'h00;
    localparam logic [5:0] CMD_LOAD_BOTH = 6'h01;
    localparam logic [5:0] CMD_LOAD_A = 6'h02;
    localparam logic [5:0] CMD_LOAD_B = 6'h03;
    localparam logic [5:0] CMD_IN_BOTH = 6'h04;
    localparam logic [5:0] CMD_IN_A = 6'h05;
    localparam logic [5:0] CMD_IN_B = 6'h06;
    localparam logic [5:0] CMD_UPD_BOTH = 6'h07;
    localparam logic [5:0] CMD_UPD_A = 6'h09;
    localparam logic [5:0] CMD_UPD_B = 6'h0A;
    localparam logic [5:0] CMD_REF_INT = 6'h0B;
    localparam logic [5:0] CMD_REF_EXT = 6'h0C;
    localparam logic [5:0] CMD_SD_BOTH = 6'h0D;
    localparam logic [5:0] CMD_SD_A = 6'h0E;
    localparam logic [5:0] CMD_SD_B = 6'h0F;
    localparam logic [5:0] CMD_RANGE_A = 6'h10;
    localparam logic [5:0] CMD_PU_BOTH = 6'h2D;
    localparam logic [5:0] CMD_PU_A = 6'h2E;
    localparam logic [5:0] CMD_PU_B = 6'h2F;
    localparam logic [5:0] CMD_RANGE_B = 6'h30;

    // one received command: code plus value
    typedef struct packed {
        logic [CMD_W-1:0] code;
        logic [VAL_W-1:0] value;
    } ddsc_cmd_type;

    // state of one converter channel
    typedef struct packed {
        logic [VAL_W-1:0] inputReg;
        logic [VAL_W-1:0] dacReg;
        logic [RANGE_W-1:0] range;
        logic shutdown;
    } ddsc_chan_type;
endpackage : ddsc_pkg

// ---- src/ddsc_exec.sv ----
/*
 * Command executor: applies one received command to both channels and
 * the reference mode. Assumes a one-cycle execute strobe on clk.
 */
`timescale 1ns/100ps
`default_nettype none
module ddsc_exec
    import ddsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic execStb,
    input wire ddsc_pkg::ddsc_cmd_type cmd,
    output ddsc_pkg::ddsc_chan_type chanA,
    output ddsc_pkg::ddsc_chan_type chanB,
    output logic refExternal
);
    ddsc_chan_type chanA_r, chanA_nxt, chanB_r, chanB_nxt;
    logic refExt_r, refExt_nxt;

    function automatic logic inRange(input logic [5:0] code, input logic [5:0] base);
        inRange = (code >= base) && (code <= base + {3'h0, RANGE_TOP});
    endfunction : inRange

    // next state from the command; undefined codes fall through untouched
    always_comb begin
        chanA_nxt = chanA_r;
        chanB_nxt = chanB_r;
        refExt_nxt = refExt_r;
        if (execStb) begin
            case (cmd.code)
                CMD_LOAD_BOTH: begin
                    chanA_nxt.inputReg = cmd.value;
                    chanA_nxt.dacReg = cmd.value;
                    chanB_nxt.inputReg = cmd.value;
                    chanB_nxt.dacReg = cmd.value;
                end
                CMD_LOAD_A: begin
                    chanA_nxt.inputReg = cmd.value;
                    chanA_nxt.dacReg = cmd.value;
                end
                CMD_LOAD_B: begin
                    chanB_nxt.inputReg = cmd.value;
                    chanB_nxt.dacReg = cmd.value;
                end
                CMD_IN_BOTH: begin
                    chanA_nxt.inputReg = cmd.value;
                    chanB_nxt.inputReg = cmd.value;
                end
                CMD_IN_A: chanA_nxt.inputReg = cmd.value;
                CMD_IN_B: chanB_nxt.inputReg = cmd.value;
                CMD_UPD_BOTH: begin
                    chanA_nxt.dacReg = chanA_r.inputReg;
                    chanB_nxt.dacReg = chanB_r.inputReg;
                end
                CMD_UPD_A: chanA_nxt.dacReg = chanA_r.inputReg;
                CMD_UPD_B: chanB_nxt.dacReg = chanB_r.inputReg;
                CMD_REF_INT: refExt_nxt = ~REF_EXTERNAL;
                CMD_REF_EXT: refExt_nxt = REF_EXTERNAL;
                CMD_SD_BOTH: begin
                    chanA_nxt.shutdown = 1'b1;
                    chanB_nxt.shutdown = 1'b1;
                end
                CMD_SD_A: chanA_nxt.shutdown = 1'b1;
                CMD_SD_B: chanB_nxt.shutdown = 1'b1;
                CMD_PU_BOTH: begin
                    chanA_nxt.shutdown = 1'b0;
                    chanB_nxt.shutdown = 1'b0;
                end
                CMD_PU_A: chanA_nxt.shutdown = 1'b0;
                CMD_PU_B: chanB_nxt.shutdown = 1'b0;
                default: begin
                    // range codes, ascending from the smallest span
                    if (inRange(cmd.code, CMD_RANGE_A)) begin
                        chanA_nxt.range = RANGE_W'(cmd.code - CMD_RANGE_A);
                    end else if (inRange(cmd.code, CMD_RANGE_B)) begin
                        chanB_nxt.range = RANGE_W'(cmd.code - CMD_RANGE_B);
                    end
                end
            endcase
        end
    end

    // power-on defaults: external reference, lowest range, powered up
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chanA_r <= '{inputReg: '0, dacReg: '0, range: RANGE_DEFAULT, shutdown: 1'b0};
            chanB_r <= '{inputReg: '0, dacReg: '0, range: RANGE_DEFAULT, shutdown: 1'b0};
            refExt_r <= REF_EXTERNAL;
        end else begin
            chanA_r <= chanA_nxt;
            chanB_r <= chanB_nxt;
            refExt_r <= refExt_nxt;
        end
    end

    assign chanA = chanA_r;
    assign chanB = chanB_r;
    assign refExternal = refExt_r;
endmodule : ddsc_exec
`default_nettype wire

// ---- verification/ddsc_chk_props.sv ----
/*
 * Assertions on the pins of ddsc_top.
 * Assumes pins reach clk through a two-flop synchroniser.
 */
`timescale 1ns/100ps
`default_nettype none
module ddsc_chk
    import ddsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spiSelect,
    input wire logic serialClk,
    input wire logic sdaOe,
    input wire logic chipSel_b,
    input wire logic [VAL_W-1:0] channelACode,
    input wire logic [VAL_W-1:0] channelBCode,
    input wire logic [RANGE_W-1:0] channelARange,
    input wire logic [RANGE_W-1:0] channelBRange,
    input wire logic channelAEnable,
    input wire logic channelBEnable,
    input wire logic refExternal
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // pin levels two cycles back, past the synchroniser delay
    sequence sclWasHigh; $past(serialClk, 2); endsequence
    sequence csWasHigh; $past(chipSel_b, 2); endsequence

    a_spi_no_ack: assert property (spiSelect && $past(spiSelect, 4) |-> !sdaOe)
        else $error("sda pulled in spi mode");
    a_ack_rise_low: assert property ($rose(sdaOe) |-> $past(!serialClk, 2))
        else $error("ack started with scl high");
    a_ack_fall_low: assert property ($fell(sdaOe) |-> $past(!serialClk, 2))
        else $error("ack ended with scl high");
    a_spi_code_cs: assert property (spiSelect && $changed({channelACode, channelBCode})
        |-> csWasHigh) else $error("code changed inside spi frame");
    a_spi_mode_cs: assert property (spiSelect && $changed({refExternal, channelARange,
        channelBRange, channelAEnable, channelBEnable}) |-> csWasHigh)
        else $error("mode changed inside spi frame");
    a_i2c_code_scl: assert property (!spiSelect && $changed({channelACode, channelBCode})
        |-> sclWasHigh) else $error("code changed off scl rise");
    a_i2c_mode_scl: assert property (!spiSelect && $changed({refExternal, channelARange,
        channelBRange, channelAEnable, channelBEnable}) |-> sclWasHigh)
        else $error("mode changed off scl rise");
    a_reset_state: assert property ($past(!rst_b) |-> refExternal && channelAEnable
        && channelBEnable && channelARange == RANGE_DEFAULT
        && channelBRange == RANGE_DEFAULT) else $error("bad power-on state");
    a_range_top: assert property (channelARange <= RANGE_TOP && channelBRange <= RANGE_TOP)
        else $error("range out of set");
endmodule : ddsc_chk

bind ddsc_top ddsc_chk chk_u (.clk(clk), .rst_b(rst_b), .spiSelect(spiSelect),
    .serialClk(serialClk), .sdaOe(sdaOe), .chipSel_b(chipSel_b),
    .channelACode(channelACode), .channelBCode(channelBCode),
    .channelARange(channelARange), .channelBRange(channelBRange),
    .channelAEnable(channelAEnable), .channelBEnable(channelBEnable),
    .refExternal(refExternal));
`default_nettype wire

// ---- verification/ddsc_master.sv ----
/*
 * Serial bus master model for spi and i2c.
 * Assumes a pull-up on sda outside and tasks called by the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module ddsc_master (
    input wire logic clk,
    input wire logic sdaIn,
    output var logic sclk_r,
    output var logic dat_r,
    output var logic chipSel_b_r
);
    // idle: clock parked high, sda released, select off
    initial begin
        sclk_r = 1'b1;
        dat_r = 1'b1;
        chipSel_b_r = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // data moves a cycle after the fall, so no false start or stop
    task automatic clkBit(input logic b, output logic s);
        tick(1);
        sclk_r <= 1'b0;
        tick(1);
        dat_r <= b;
        tick(3);
        sclk_r <= 1'b1;
        tick(2);
        #1 s = sdaIn;
        tick(1);
    endtask : clkBit

    // start is cond(1,0), stop is cond(0,1)
    task automatic cond(input logic a, input logic b);
        tick(1);
        sclk_r <= 1'b0;
        tick(1);
        dat_r <= a;
        tick(3);
        sclk_r <= 1'b1;
        tick(3);
        dat_r <= b;
        tick(4);
    endtask : cond

    // select held low over all 16 bits; din scrambled after
    task automatic spiFrame(input logic [15:0] f);
        logic s;
        tick(1);
        chipSel_b_r <= 1'b0;
        for (int i = 15; i >= 0; i--) clkBit(f[i], s);
        tick(3);
        chipSel_b_r <= 1'b1;
        dat_r <= ~dat_r;
        tick(6);
    endtask : spiFrame

    // ack clock only for whole bytes; sda released there
    task automatic i2cByte(input logic [7:0] b, input int nb, output logic ack);
        logic s;
        for (int i = 7; i >= 8 - nb; i--) clkBit(b[i], s);
        ack = 1'b1;
        if (nb == 8) clkBit(1'b1, ack);
    endtask : i2cByte
endmodule : ddsc_master
`default_nettype wire

// ---- verification/tb_top.sv ----
/*
 * Bench of ddsc_top: spi then i2c traffic against a command model.
 * Assumes ddsc_master drives the pins and ddsc_chk is bound.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ddsc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic spiSelect = 1'b1;
    logic strapLo = 1'b0;
    logic strapHi = 1'b0;
    wire logic sclk, mdat, csel_b, sdaOut, sdaOe, dataIn, rEx, eA, eB;
    wire logic [9:0] codeA, codeB;
    wire logic [2:0] rngA, rngB;
    wire logic [28:0] outVec;
    int n_mismatch = 0;
    int tests_run = 0;
    int ia, ib, da, db, ra, rb, ea, eb, rx, c, v;
    logic [2:0] acks;
    logic [7:0] adr;
    int cl[12] = '{13, 1, 9, 11, 45, 20, 52, 1, 2, 3, 5, 7};

    always #10 clk = ~clk;

    // open drain: released sda reads high unless someone pulls
    assign dataIn = sdaOe ? sdaOut : mdat;
    assign outVec = {codeA, codeB, rngA, rngB, eA, eB, rEx};

    ddsc_top dut_u (.clk(clk), .rst_b(rst_b), .spiSelect(spiSelect), .serialClk(sclk),
        .dataIn(dataIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSel_b(csel_b),
        .addressStrapLow(strapLo), .addressStrapHigh(strapHi), .channelACode(codeA),
        .channelBCode(codeB), .channelARange(rngA), .channelBRange(rngB),
        .channelAEnable(eA), .channelBEnable(eB), .refExternal(rEx));
    ddsc_master mdl_u (.clk(clk), .sdaIn(dataIn), .sclk_r(sclk), .dat_r(mdat),
        .chipSel_b_r(csel_b));

    // reference model of one command; unknown codes fall through
    function automatic void apply(input int k, input int w);
        if (k inside {1, 2, 4, 5}) ia = w;
        if (k inside {1, 3, 4, 6}) ib = w;
        if (k inside {1, 2}) da = w;
        if (k inside {1, 3}) db = w;
        if (k inside {7, 9}) da = ia;
        if (k inside {7, 10}) db = ib;
        if (k inside {11, 12}) rx = k - 11;
        if (k inside {13, 14, 45, 46}) ea = k / 45;
        if (k inside {13, 15, 45, 47}) eb = k / 45;
        if (k >= 16 && k <= 21) ra = k - 16;
        if (k >= 48 && k <= 53) rb = k - 48;
    endfunction : apply

    // expected pins from the model, packed like outVec
    function automatic logic [28:0] expVec();
        return {da[9:0], db[9:0], ra[2:0], rb[2:0], ea[0], eb[0], rx[0]};
    endfunction : expVec

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    // hang guard, about four times the expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        v = $urandom(47957);
        {ia, ib, da, db, ra, rb} = '0;
        {ea, eb, rx} = {32'd1, 32'd1, 32'd1};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk({outVec, 3'h0}, {expVec(), 3'h0});
        // every code once over spi, then random codes
        for (int i = 0; i < 84; i++) begin
            c = (i < 64) ? i : $urandom % 64;
            v = $urandom % 1024;
            mdl_u.spiFrame({c[5:0], v[9:0]});
            apply(c, v);
            repeat (8) @(posedge clk);
            chk({outVec, 3'h0}, {expVec(), 3'h0});
        end
        spiSelect <= 1'b0;
        strapLo <= 1'($urandom);
        strapHi <= 1'($urandom);
        repeat (8) @(posedge clk);
        // i2c: foreign and read addresses, an abort, repeated starts
        for (int i = 0; i < 12; i++) begin
            c = cl[i];
            v = $urandom % 1024;
            adr = {5'h0C, strapHi, strapLo, 1'b0} ^ ((i == 5) ? 8'h02 : 8'h00);
            adr[0] = (i == 6);
            mdl_u.cond(1'b1, 1'b0);
            mdl_u.i2cByte(adr, 8, acks[2]);
            mdl_u.i2cByte({c[5:0], v[9:8]}, 8, acks[1]);
            // abort two bits short: the stop's own clock is then not the 26th
            mdl_u.i2cByte(v[7:0], (i == 7) ? 6 : 8, acks[0]);
            if (i % 3 != 0 || i == 7) mdl_u.cond(1'b0, 1'b1);
            if (i < 5 || i > 7) apply(c, v);
            repeat (8) @(posedge clk);
            chk({outVec, acks}, {expVec(),
                (i == 5 || i == 6) ? 3'h7 : ((i == 7) ? 3'h1 : 3'h0)});
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
